// ==== src/acf_regs.sv ====
`timescale 1ns/1ps
module acf_regs
  import acf_pkg::*;
#(
  parameter int PULSE_CYC = ACF_PULSE_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] cellCount,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWdata,
  input  wire logic       regRead,
  output logic [7:0]      regRdata,
  input  wire logic [2:0] chargeCycleState,
  input  wire logic       batteryOvervoltageFault,
  input  wire logic       overcurrentFault,
  input  wire logic       internalRegulatorFault,
  input  wire logic       safetyTimerExpired,
  input  wire logic       safetyTimerEnableIn,
  output logic            autoChargeEnable,
  output logic [3:0]      rechargeThreshold,
  output logic [9:0]      rechargeThresholdMv,
  output logic [1:0]      safetyTimerDuration,
  output logic [4:0]      safetyTimerHours,
  output logic            safetyTimerEnable,
  output logic            safetyTimerStatus,
  output logic            adapterGoodOutputOut,
  output logic            adapterGoodOutputOe
);
  logic                 rstMeta_r;
  logic                 rstSync_r;
  logic                 strapDone_r;
  logic                 strapDone_nxt;
  logic                 auto_r;
  logic                 auto_nxt;
  logic                 pulseEn_r;
  logic                 pulseEn_nxt;
  logic [3:0]           rechg_r;
  logic [3:0]           rechg_nxt;
  logic [1:0]           tmr_r;
  logic [1:0]           tmr_nxt;
  logic [2:0]           stPrev_r;
  logic [ACF_CNT_W-1:0] pulseCnt_r;
  logic [ACF_CNT_W-1:0] pulseCnt_nxt;
  logic [7:0]           rdata_r;
  logic [7:0]           rdata_nxt;
  logic [7:0]           faultVec;
  logic                 faultVecOvp;
  logic                 faultVecOcp;
  logic                 faultVecRegn;
  logic                 faultRead;
  logic [3:0]           strapCode;

  // reset release through two flops; data only flop, no logic on the first
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  always_comb begin
    case (acf_cells_t'(cellCount))
      ACF_CELL2: strapCode = ACF_RECHG_2S;
      ACF_CELL3: strapCode = ACF_RECHG_3S;
      ACF_CELL4: strapCode = ACF_RECHG_4S;
      ACF_CELL5: strapCode = ACF_RECHG_5S;
      default:   strapCode = ACF_RECHG_2S;
    endcase
  end

  assign faultRead = regRead && (regAddr == ACF_ADDR_FAULT);

  always_comb begin
    auto_nxt      = auto_r;
    pulseEn_nxt   = pulseEn_r;
    rechg_nxt     = rechg_r;
    tmr_nxt       = tmr_r;
    strapDone_nxt = 1'b1;
    // cell-count strap is caught on the first clocked cycle after release
    if (!strapDone_r) begin
      rechg_nxt = strapCode;
    end
    if (regWrite && regAddr == ACF_ADDR_CTRL) begin
      auto_nxt    = regWdata[ACF_BIT_AUTO];
      pulseEn_nxt = regWdata[ACF_BIT_PULSE_EN];
      rechg_nxt   = regWdata[ACF_RECHG_HI:ACF_RECHG_LO];
      tmr_nxt     = regWdata[ACF_TMR_HI:ACF_TMR_LO];
    end
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (regRead) begin
      case (regAddr)
        ACF_ADDR_CTRL:  rdata_nxt = {auto_r, pulseEn_r, rechg_r, tmr_r};
        ACF_ADDR_FAULT: rdata_nxt = faultVec;
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  // pulse timer; a new change reloads it, so back-to-back changes stretch the low time
  always_comb begin
    pulseCnt_nxt = pulseCnt_r;
    if (pulseCnt_r != '0) begin
      pulseCnt_nxt = pulseCnt_r - 1'b1;
    end
    if (pulseEn_r && (chargeCycleState != stPrev_r)) begin
      pulseCnt_nxt = ACF_CNT_W'(PULSE_CYC);
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      auto_r      <= 1'b0;
      pulseEn_r   <= 1'b0;
      rechg_r     <= ACF_RECHG_2S;
      tmr_r       <= ACF_TMR_RST;
      strapDone_r <= 1'b0;
      stPrev_r    <= ACF_ST_IDLE;
      pulseCnt_r  <= '0;
      rdata_r     <= ACF_FAULT_RST;
    end else begin
      auto_r      <= auto_nxt;
      pulseEn_r   <= pulseEn_nxt;
      rechg_r     <= rechg_nxt;
      tmr_r       <= tmr_nxt;
      strapDone_r <= strapDone_nxt;
      stPrev_r    <= chargeCycleState;
      pulseCnt_r  <= pulseCnt_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // reserved positions keep the reset pattern, so they always read zero
  always_comb begin
    faultVec               = ACF_FAULT_RST;
    faultVec[ACF_BIT_OVP]  = faultVecOvp;
    faultVec[ACF_BIT_OCP]  = faultVecOcp;
    faultVec[ACF_BIT_REGN] = faultVecRegn;
  end

  acf_fault_bit uOvp (
    .clk     (ref_clk),
    .rstB    (rstSync_r),
    .faultIn (batteryOvervoltageFault),
    .readDone(faultRead),
    .bitOut  (faultVecOvp)
  );
  acf_fault_bit uOcp (
    .clk     (ref_clk),
    .rstB    (rstSync_r),
    .faultIn (overcurrentFault),
    .readDone(faultRead),
    .bitOut  (faultVecOcp)
  );
  acf_fault_bit uRegn (
    .clk     (ref_clk),
    .rstB    (rstSync_r),
    .faultIn (internalRegulatorFault),
    .readDone(faultRead),
    .bitOut  (faultVecRegn)
  );

  always_comb begin
    case (tmr_r)
      2'h0:    safetyTimerHours = {1'b0, ACF_TMR_HOURS_00};
      2'h1:    safetyTimerHours = ACF_TMR_HOURS_01;
      2'h2:    safetyTimerHours = ACF_TMR_HOURS_10;
      default: safetyTimerHours = ACF_TMR_HOURS_11;
    endcase
  end

  // millivolts for the analog side: offset plus one step per code
  assign rechargeThresholdMv  = 10'(ACF_RECHG_OFS_MV) + 10'(ACF_RECHG_STEP_MV) * {6'h00, rechg_r};
  assign autoChargeEnable     = auto_r;
  assign rechargeThreshold    = rechg_r;
  assign safetyTimerDuration  = tmr_r;
  assign safetyTimerEnable    = safetyTimerEnableIn;
  assign safetyTimerStatus    = safetyTimerExpired && safetyTimerEnableIn;
  assign regRdata             = rdata_r;
  // open drain: oe low means pulling low
  assign adapterGoodOutputOut = 1'b0;
  assign adapterGoodOutputOe  = (pulseCnt_r == '0);
endmodule

// ==== src/acf_pkg.sv ====
// Function
// - One control bit, zero after reset, lets the device restart and end charging on its own.
// - With the pulse enable set, every change of the charge cycle state pulls the adapter-good output low for at least 256 us.
// - With the pulse enable clear, its reset value, state changes give no low pulse.
// - The 4-bit recharge threshold in bits 5:2 means 50 mV plus 50 mV per code below the voltage setpoint.
// - The threshold resets to code 3, 5, 7 or 9 for two, three, four or five cells.
// - The safety timer field sits in bits 1:0, is read/write and resets to code 1 (8 hours).
// - A fault bit sets when its fault is seen and stays set until the host reads the status register.
// - A fault still present during the host read keeps its bit at 1.
// - After one read of a set bit, the bit clears by itself once the fault is gone.
// - The fault register is read-only, resets to zero, bit 7 overvoltage, 5 overcurrent, 3 regulator, others zero.
// - The charge cycle state is three bits with 000 idle up to 111 termination done, 101 and 110 reserved.
// - A safety timer enable, set at reset, turns the timer on; its expiry shows in a read-only status bit.
//   Here the enable follows the safetyTimerEnableIn input and has no reset value of its own.
package acf_pkg;
  localparam logic [7:0] ACF_ADDR_CTRL     = 8'h17;
  localparam logic [7:0] ACF_ADDR_FAULT    = 8'h18;
  localparam int         ACF_BIT_AUTO      = 7;
  localparam int         ACF_BIT_PULSE_EN  = 6;
  localparam int         ACF_RECHG_HI      = 5;
  localparam int         ACF_RECHG_LO      = 2;
  localparam int         ACF_TMR_HI        = 1;
  localparam int         ACF_TMR_LO        = 0;
  localparam int         ACF_BIT_OVP       = 7;
  localparam int         ACF_BIT_OCP       = 5;
  localparam int         ACF_BIT_REGN      = 3;
  localparam logic [1:0] ACF_TMR_RST       = 2'h1;
  localparam logic [7:0] ACF_FAULT_RST     = 8'h00;
  localparam logic [3:0] ACF_RECHG_2S      = 4'h3;
  localparam logic [3:0] ACF_RECHG_3S      = 4'h5;
  localparam logic [3:0] ACF_RECHG_4S      = 4'h7;
  localparam logic [3:0] ACF_RECHG_5S      = 4'h9;
  localparam int         ACF_RECHG_STEP_MV = 50;
  localparam int         ACF_RECHG_OFS_MV  = 50;
  localparam int         ACF_PULSE_US      = 256;
  localparam int         ACF_CLK_MHZ       = 100;
  localparam int         ACF_PULSE_CYC     = ACF_PULSE_US * ACF_CLK_MHZ;
  localparam int         ACF_CNT_W         = $clog2(ACF_PULSE_CYC + 1);
  localparam logic [3:0] ACF_TMR_HOURS_00  = 4'h5;
  localparam logic [4:0] ACF_TMR_HOURS_01  = 5'h08;
  localparam logic [4:0] ACF_TMR_HOURS_10  = 5'h0c;
  localparam logic [4:0] ACF_TMR_HOURS_11  = 5'h18;
  typedef enum logic [1:0] {ACF_CELL2, ACF_CELL3, ACF_CELL4, ACF_CELL5} acf_cells_t;
  typedef enum logic [2:0] {
    ACF_ST_IDLE    = 3'h0,
    ACF_ST_TRICKLE = 3'h1,
    ACF_ST_PRE     = 3'h2,
    ACF_ST_CC      = 3'h3,
    ACF_ST_CV      = 3'h4,
    ACF_ST_RSV1    = 3'h5,
    ACF_ST_RSV2    = 3'h6,
    ACF_ST_DONE    = 3'h7
  } acf_chg_state_t;
endpackage

// ==== src/acf_fault_bit.sv ====
`timescale 1ns/1ps
module acf_fault_bit (
  input  wire logic clk,
  input  wire logic rstB,
  input  wire logic faultIn,
  input  wire logic readDone,
  output logic      bitOut
);
  logic latch_r;
  logic latch_nxt;
  logic seen_r;
  logic seen_nxt;

  always_comb begin
    latch_nxt = latch_r;
    seen_nxt  = seen_r;
    if (readDone && latch_r) begin
      seen_nxt = 1'b1;
    end
    if (seen_r && !faultIn) begin
      latch_nxt = 1'b0;
      seen_nxt  = 1'b0;
    end
    if (readDone && latch_r && !faultIn) begin
      latch_nxt = 1'b0;
      seen_nxt  = 1'b0;
    end
    // a live fault always wins over any clear
    if (faultIn) begin
      latch_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      latch_r <= 1'b0;
      seen_r  <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      seen_r  <= seen_nxt;
    end
  end

  assign bitOut = latch_r;
endmodule

// ==== testbench/acf_host_model.sv ====
`timescale 1ns/1ps
module acf_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] regRdata,
  output logic [7:0]      regAddr,
  output logic            regWrite,
  output logic [7:0]      regWdata,
  output logic            regRead
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWdata = 8'h00;
    regRead = 1'b0;
  end
  // released lines show the inverse so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge ref_clk);
    regRead = 1'b0;
    regAddr = ~a;
    d = regRdata;
  endtask
endmodule

// ==== testbench/acf_regs_chk.sv ====
`timescale 1ns/1ps
module acf_regs_chk
  import acf_pkg::*;
#(parameter int PULSE_CYC = ACF_PULSE_CYC) (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic [7:0] regWdata,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic [2:0] chargeCycleState,
  input wire logic       batteryOvervoltageFault,
  input wire logic       autoChargeEnable,
  input wire logic [3:0] rechargeThreshold,
  input wire logic [9:0] rechargeThresholdMv,
  input wire logic [1:0] safetyTimerDuration,
  input wire logic [4:0] safetyTimerHours,
  input wire logic       adapterGoodOutputOe
);
  logic        pEn_r;
  logic [2:0]  stPrev_r;
  logic [15:0] since_r;
  // shadow of the pulse enable, which has no port of its own
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pEn_r <= 1'b0;
      stPrev_r <= 3'h0;
      since_r <= 16'h0000;
    end else begin
      if (regWrite && regAddr == ACF_ADDR_CTRL) pEn_r <= regWdata[ACF_BIT_PULSE_EN];
      stPrev_r <= chargeCycleState;
      since_r <= (chargeCycleState != stPrev_r) ? 16'h0000 : since_r + 16'(since_r != 16'hffff);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence stChgEn;
    pEn_r && chargeCycleState != stPrev_r;
  endsequence
  sequence ctrlRd;
    regRead && regAddr == ACF_ADDR_CTRL;
  endsequence
  pulse_start_a: assert property (stChgEn |=> !adapterGoodOutputOe)
    else $error("no pulse after change");
  pulse_cause_a: assert property ($fell(adapterGoodOutputOe) |->
    $past(pEn_r && chargeCycleState != stPrev_r)) else $error("pulse without enabled change");
  pulse_len_a: assert property ($rose(adapterGoodOutputOe) |-> since_r == PULSE_CYC)
    else $error("pulse length");
  pulse_end_a: assert property (since_r > PULSE_CYC |-> adapterGoodOutputOe)
    else $error("pulse too long");
  ctrl_read_a: assert property (ctrlRd |=>
    regRdata == {autoChargeEnable, pEn_r, rechargeThreshold, safetyTimerDuration}) else $error("ctrl read data");
  fault_rsvd_a: assert property (regRead && regAddr == ACF_ADDR_FAULT |=> (regRdata & 8'h57) == 8'h00)
    else $error("reserved fault bits");
  field_decode_a: assert property (
    rechargeThresholdMv == 10'(50 + 50 * rechargeThreshold) && safetyTimerHours == (safetyTimerDuration == 2'h0 ?
    5'h05 : safetyTimerDuration == 2'h1 ? 5'h08 : safetyTimerDuration == 2'h2 ? 5'h0c : 5'h18))
    else $error("field decode");
  ctrl_write_a: assert property (regWrite && regAddr == ACF_ADDR_CTRL |=>
    {autoChargeEnable, rechargeThreshold, safetyTimerDuration} == {$past(regWdata[7]), $past(regWdata[5:0])})
    else $error("ctrl write");
  ovp_keep_a: assert property ($past(batteryOvervoltageFault) && regRead && regAddr == ACF_ADDR_FAULT |=>
    regRdata[ACF_BIT_OVP]) else $error("fault bit lost");
endmodule
bind acf_regs acf_regs_chk #(.PULSE_CYC(PULSE_CYC)) u_acf_regs_chk (.*);

// ==== testbench/acf_regs_tb.sv ====
`timescale 1ns/1ps
module acf_regs_tb;
  import acf_pkg::*;
  localparam int PC = 20;
  logic       ref_clk, rst_b, regWrite, regRead, tmrExp, tmrEnIn, oe;
  logic [1:0] cellCount;
  logic [2:0] st, flt;
  logic [7:0] regAddr, regWdata, regRdata, v, w;
  logic [9:0] mv;
  logic [4:0] hrs;
  logic       tmrEn, tmrSt, aOut;
  int         bad_count, n_compared, i, n;
  acf_regs #(.PULSE_CYC(PC)) u_acf_regs (.ref_clk(ref_clk), .rst_b(rst_b), .cellCount(cellCount),
    .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata),
    .chargeCycleState(st), .batteryOvervoltageFault(flt[0]), .overcurrentFault(flt[1]),
    .internalRegulatorFault(flt[2]), .safetyTimerExpired(tmrExp), .safetyTimerEnableIn(tmrEnIn),
    .autoChargeEnable(), .rechargeThreshold(), .rechargeThresholdMv(mv), .safetyTimerDuration(),
    .safetyTimerHours(hrs), .safetyTimerEnable(tmrEn), .safetyTimerStatus(tmrSt),
    .adapterGoodOutputOut(aOut), .adapterGoodOutputOe(oe));
  acf_host_model u_acf_host_model (.ref_clk(ref_clk), .regRdata(regRdata), .regAddr(regAddr),
    .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead));
  function automatic logic [9:0] hoursOf(input logic [1:0] c);
    return (c == 2'h0) ? 10'h005 : (c == 2'h1) ? 10'h008 : (c == 2'h2) ? 10'h00c : 10'h018;
  endfunction
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // counts low cycles of the pin; the bound catches a pulse that never ends
  task automatic meas(output int c);
    // the pulse starts at the edge before this negedge, so its first low cycle is counted
    @(negedge ref_clk);
    c = 0;
    while (oe !== 1'b1 && c < 200) begin
      c++;
      @(negedge ref_clk);
    end
    if (c == 200) bad_count++;
    if (c == 200) complete_run();
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    bad_count = 0;
    n_compared = 0;
    void'($urandom(15413));
    cellCount = 2'($urandom_range(3));
    {st, flt, tmrExp, tmrEnIn} = 8'h01;
    rst_b = 1'b0;
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    u_acf_host_model.rd(ACF_ADDR_CTRL, v);
    chk("ctrl reset", {4'h0, 4'h3 + 4'(2 * cellCount), 2'h1}, {2'h0, v});
    u_acf_host_model.rd(ACF_ADDR_FAULT, v);
    chk("fault reset", 10'h000, {2'h0, v});
    u_acf_host_model.rd(8'h20, v);
    chk("unmapped", 10'h000, {2'h0, v});
    for (i = 0; i < 6; i++) begin
      w = (i < 4) ? {2'h0, 4'(i * 5), 2'(i)} : 8'($urandom) & 8'hbf;
      u_acf_host_model.wr(ACF_ADDR_CTRL, w);
      u_acf_host_model.rd(ACF_ADDR_CTRL, v);
      chk("ctrl rw", {2'h0, w}, {2'h0, v});
      chk("mv", 10'(50 + 50 * w[5:2]), mv);
      chk("hours", hoursOf(w[1:0]), {5'h00, hrs});
    end
    u_acf_host_model.wr(ACF_ADDR_FAULT, 8'hff);
    u_acf_host_model.rd(ACF_ADDR_FAULT, v);
    chk("fault ro", 10'h000, {2'h0, v});
    st = 3'h5;
    meas(n);
    chk("no pulse", 10'h000, 10'(n));
    u_acf_host_model.wr(ACF_ADDR_CTRL, 8'h40);
    for (i = 0; i < 8; i++) begin
      st = 3'(i);
      meas(n);
      chk("pulse", 10'(PC), 10'(n));
    end
    st = 3'h2;
    repeat (5) @(negedge ref_clk);
    chk("pin low", 10'h000, {8'h00, aOut, oe});
    st = 3'h3;
    meas(n);
    chk("restart", 10'(PC), 10'(n));
    for (i = 0; i < 3; i++) begin
      flt = 3'(1 << i);
      @(negedge ref_clk);
      flt = 3'h0;
      u_acf_host_model.rd(ACF_ADDR_FAULT, v);
      chk("latched", 10'(8'h80 >> (2 * i)), {2'h0, v});
      u_acf_host_model.rd(ACF_ADDR_FAULT, v);
      chk("read clear", 10'h000, {2'h0, v});
      flt = 3'(1 << i);
      repeat (2) u_acf_host_model.rd(ACF_ADDR_FAULT, v);
      chk("held", 10'(8'h80 >> (2 * i)), {2'h0, v});
      flt = 3'h0;
      repeat (2) @(negedge ref_clk);
      u_acf_host_model.rd(ACF_ADDR_FAULT, v);
      chk("auto clear", 10'h000, {2'h0, v});
    end
    // a disabled timer cannot report expiry
    for (i = 0; i < 4; i++) begin
      {tmrExp, tmrEnIn} = 2'(i);
      @(negedge ref_clk);
      chk("timer", {8'h00, tmrExp & tmrEnIn, tmrEnIn}, {8'h00, tmrSt, tmrEn});
    end
    // every strap value gets its own mid-run reset
    for (i = 0; i < 4; i++) begin
      cellCount = 2'(i);
      rst_b = 1'b0;
      @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      u_acf_host_model.rd(ACF_ADDR_CTRL, v);
      chk("ctrl rereset", {4'h0, 4'h3 + 4'(2 * cellCount), 2'h1}, {2'h0, v});
    end
    complete_run();
  end
endmodule
